// ===== hw/pisc_pump_drv.sv
`timescale 1ns/1ps
`default_nettype none
module pisc_pump_drv #(
  parameter bit INVERT = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // control
  input wire logic gate_i,
  input wire logic fast_i,
  input wire logic slow_i,
  // pin
  output logic pump_o,
  output logic pump_oe_o
);
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pump_oe_o <= 1'b0;
    end else begin
      pump_oe_o <= gate_i && (fast_i != slow_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pump_o <= 1'b0;
    end else if (fast_i && !slow_i) begin
      pump_o <= ~INVERT;
    end else if (slow_i && !fast_i) begin
      pump_o <= INVERT;
    end
  end
endmodule
`default_nettype wire

// ===== hw/pisc_top.sv
// Notes on behaviour
// RQ1 - fm select ignores band bits
// RQ2 - am select, band from two low bits
// RQ3 - hold low with enable gates inputs
// RQ4 - stop, clock stop, reset gate inputs
// RQ5 - second pump low fast, high slow
// RQ6 - second pump floats on match
// RQ7 - second pump floats during hold
// RQ8 - second pump floats when stopped
// RQ9 - instruction drives sub pump output
// RQ10 - main pumps use opposite polarity
// RQ11 - enables cleared on any gate condition
`timescale 1ns/1ps
`default_nettype none
`include "pisc_defs.svh"
module pisc_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // oscillator inputs
  input wire logic fm_osc_input_i,
  input wire logic am_osc_input_i,
  // mode conditions
  input wire logic hold_n_i,
  input wire logic hold_en_i,
  input wire logic clock_stop_i,
  input wire logic por_i,
  input wire logic synth_stop_i,
  // control word and instruction
  input wire logic cw_load_i,
  input wire logic [2:0] synth_control_word_one_i,
  input wire logic sub_load_i,
  input wire logic [1:0] sub_pump_control_instr_i,
  // phase comparator
  input wire logic div_fast_i,
  input wire logic div_slow_i,
  // divider side
  output logic div_in_o,
  output pisc_pkg::pisc_src_t src_o,
  output logic am_band_short_o,
  // pump pins
  output logic main_pump_output_a_o,
  output logic main_pump_output_a_oe_o,
  output logic main_pump_output_b_o,
  output logic main_pump_output_b_oe_o,
  output logic second_pump_output_o,
  output logic second_pump_output_oe_o,
  output logic sub_pump_output_o,
  output logic sub_pump_output_oe_o
);
  import pisc_pkg::*;

  ////////////////////////////////////////////////////////////////
  logic [2:0] word;
  logic [1:0] sub_mode;
  logic gate;
  logic hold_act;
  logic next_div_in;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      word <= `PISC_RST_WORD;
    end else if (cw_load_i) begin
      word <= synth_control_word_one_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sub_mode <= `PISC_RST_SUB;
    end else if (sub_load_i) begin
      sub_mode <= sub_pump_control_instr_i;
    end
  end

  // RQ3 hold gating
  assign hold_act = !hold_n_i && hold_en_i;
  // RQ4 stop gating, RQ11 shared gate
  assign gate = !hold_act && !clock_stop_i && !por_i && !synth_stop_i && nrst_i;

  ////////////////////////////////////////////////////////////////
  // band pattern 0,x under am select is undefined; treated as no source
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      src_o <= pisc_src_fm;
    end else if (word[`PISC_CW_SEL_BIT] == `PISC_CW_SEL_FM) begin
      // RQ1 band bits ignored
      src_o <= pisc_src_fm;
    end else if (word[`PISC_CW_BAND_HI]) begin
      // RQ2 am band select
      src_o <= word[`PISC_CW_BAND_LO] ? pisc_src_am_mw : pisc_src_am_sw;
    end else begin
      src_o <= pisc_src_none;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      am_band_short_o <= 1'b0;
    end else begin
      am_band_short_o <= (src_o == pisc_src_am_sw);
    end
  end

  always_comb begin
    next_div_in = 1'b0;
    unique case (src_o)
      pisc_src_fm: next_div_in = fm_osc_input_i;
      pisc_src_am_sw, pisc_src_am_mw: next_div_in = am_osc_input_i;
      pisc_src_none: next_div_in = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      div_in_o <= 1'b0;
    end else begin
      // RQ3 RQ4 input disabled
      div_in_o <= gate ? next_div_in : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // RQ10 main pump polarity
  pisc_pump_drv #(.INVERT(1'b0)) u_main_a (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .gate_i(gate),
    .fast_i(div_fast_i),
    .slow_i(div_slow_i),
    .pump_o(main_pump_output_a_o),
    .pump_oe_o(main_pump_output_a_oe_o)
  );

  pisc_pump_drv #(.INVERT(1'b0)) u_main_b (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .gate_i(gate),
    .fast_i(div_fast_i),
    .slow_i(div_slow_i),
    .pump_o(main_pump_output_b_o),
    .pump_oe_o(main_pump_output_b_oe_o)
  );

  // RQ5 RQ6 RQ7 RQ8 inverted second pump
  pisc_pump_drv #(.INVERT(1'b1)) u_second (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .gate_i(gate),
    .fast_i(div_fast_i),
    .slow_i(div_slow_i),
    .pump_o(second_pump_output_o),
    .pump_oe_o(second_pump_output_oe_o)
  );

  ////////////////////////////////////////////////////////////////
  // sub pump boosts lock speed; auto follows main polarity while off lock
  logic sub_fast;
  logic sub_slow;
  always_comb begin
    sub_fast = 1'b0;
    sub_slow = 1'b0;
    unique case (sub_mode)
      `PISC_SUB_OFF: begin
        sub_fast = 1'b0;
        sub_slow = 1'b0;
      end
      `PISC_SUB_UP: sub_fast = 1'b1;
      `PISC_SUB_DN: sub_slow = 1'b1;
      `PISC_SUB_AUTO: begin
        sub_fast = div_fast_i;
        sub_slow = div_slow_i;
      end
    endcase
  end

  // RQ9 sub pump control
  pisc_pump_drv #(.INVERT(1'b0)) u_sub (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .gate_i(gate),
    .fast_i(sub_fast),
    .slow_i(sub_slow),
    .pump_o(sub_pump_output_o),
    .pump_oe_o(sub_pump_output_oe_o)
  );
endmodule
`default_nettype wire

// ===== include/pisc_defs.svh
`ifndef PISC_DEFS_SVH
`define PISC_DEFS_SVH
// control word field positions
`define PISC_CW_SEL_BIT 2
`define PISC_CW_BAND_HI 1
`define PISC_CW_BAND_LO 0
// control word select values
`define PISC_CW_SEL_FM 1'h0
`define PISC_CW_SEL_AM 1'h1
// sub pump instruction codes
`define PISC_SUB_OFF 2'h0
`define PISC_SUB_UP 2'h1
`define PISC_SUB_DN 2'h2
`define PISC_SUB_AUTO 2'h3
// reset values
`define PISC_RST_WORD 3'h0
`define PISC_RST_SUB 2'h0
`endif

// ===== include/pisc_pkg.sv
package pisc_pkg;
  typedef enum logic [1:0] {
    pisc_src_fm,
    pisc_src_am_sw,
    pisc_src_am_mw,
    pisc_src_none
  } pisc_src_t;
  typedef enum logic [1:0] {
    pisc_cmp_match,
    pisc_cmp_high,
    pisc_cmp_low
  } pisc_cmp_t;
endpackage

// ===== tb/pisc_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "pisc_defs.svh"
module pisc_chk (
  input wire logic clk_i, nrst_i, hold_n_i, hold_en_i, clock_stop_i, por_i, synth_stop_i,
  input wire logic cw_load_i, sub_load_i, div_fast_i, div_slow_i, div_in_o, am_band_short_o,
  input wire logic [2:0] synth_control_word_one_i,
  input wire logic [1:0] sub_pump_control_instr_i,
  input wire pisc_pkg::pisc_src_t src_o,
  input wire logic main_pump_output_a_o, main_pump_output_a_oe_o, second_pump_output_o,
  input wire logic second_pump_output_oe_o, sub_pump_output_o, sub_pump_output_oe_o
);
  import pisc_pkg::*;
  wire g = (!hold_n_i && hold_en_i) || clock_stop_i || por_i || synth_stop_i;
  wire f = div_fast_i && !div_slow_i && !g;
  wire s = div_slow_i && !div_fast_i && !g;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  gate_in_a: assert property (g |=> !div_in_o)
    else $error("in");
  gate_oe_a: assert property (g |=> !second_pump_output_oe_o && !sub_pump_output_oe_o)
    else $error("oe");
  match_a: assert property (div_fast_i == div_slow_i |=> !main_pump_output_a_oe_o)
    else $error("match");
  sec_low_a: assert property (f |=> second_pump_output_oe_o && !second_pump_output_o)
    else $error("low");
  sec_high_a: assert property (s |=> second_pump_output_oe_o && second_pump_output_o)
    else $error("high");
  main_pol_a: assert property (f |=> main_pump_output_a_oe_o && main_pump_output_a_o)
    else $error("main");
  fm_sel_a: assert property (cw_load_i && !synth_control_word_one_i[2] ##1 !cw_load_i
    |=> src_o == pisc_src_fm) else $error("fm");
  am_sel_a: assert property (cw_load_i && synth_control_word_one_i == 3'h6 ##1 !cw_load_i
    |=> src_o == pisc_src_am_sw ##1 am_band_short_o) else $error("am");
  sub_up_a: assert property (sub_load_i && sub_pump_control_instr_i == `PISC_SUB_UP && !g ##1
    !sub_load_i && !g |=> sub_pump_output_oe_o && sub_pump_output_o) else $error("sub");
endmodule
bind pisc_top pisc_chk u_chk (.*);
`default_nettype wire

// ===== tb/pisc_vco.sv
`timescale 1ns/1ps
`default_nettype none
// vco stand-in: am runs at half the fm rate
module pisc_vco (
  input wire logic clk_i,
  output logic fm_o,
  output logic am_o
);
  logic [1:0] ph = 2'h0;
  always_ff @(posedge clk_i) ph <= ph + 2'h1;
  assign fm_o = ph[0];
  assign am_o = ph[1];
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pisc_defs.svh"
module testbench;
  import pisc_pkg::*;
  logic clk_i = 1'b0, nrst_i = 1'b0, hold_n_i = 1'b1, hold_en_i = 1'b0, clock_stop_i = 1'b0;
  logic por_i = 1'b0, synth_stop_i = 1'b0, cw_load_i = 1'b0, sub_load_i = 1'b0;
  logic div_fast_i = 1'b0, div_slow_i = 1'b0, fm_osc_input_i, am_osc_input_i, div_in_o;
  logic am_band_short_o, main_pump_output_a_o, main_pump_output_a_oe_o, main_pump_output_b_o;
  logic main_pump_output_b_oe_o, second_pump_output_o, second_pump_output_oe_o;
  logic sub_pump_output_o, sub_pump_output_oe_o;
  logic [2:0] synth_control_word_one_i = 3'h0;
  logic [1:0] sub_pump_control_instr_i = 2'h0;
  pisc_src_t src_o;
  int fail_count = 0;
  int total_checks = 0;
  wire [3:0] pv = {second_pump_output_oe_o, second_pump_output_o, main_pump_output_b_oe_o,
    main_pump_output_b_o};
  pisc_vco vco (.clk_i(clk_i), .fm_o(fm_osc_input_i), .am_o(am_osc_input_i));
  pisc_top dut (.*);
  initial forever #25 clk_i = ~clk_i;
  ////////////////////////////////////////
  task automatic chk(logic [3:0] got, logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic cw(logic [2:0] w);
    @(posedge clk_i);
    cw_load_i <= 1'b1;
    synth_control_word_one_i <= w;
    @(posedge clk_i);
    cw_load_i <= 1'b0;
    wt;
  endtask
  task automatic sl(logic [1:0] v);
    @(posedge clk_i);
    sub_load_i <= 1'b1;
    sub_pump_control_instr_i <= v;
    @(posedge clk_i);
    sub_load_i <= 1'b0;
    wt;
  endtask
  task automatic pc(logic f, logic s);
    @(posedge clk_i);
    div_fast_i <= f;
    div_slow_i <= s;
    wt;
  endtask
  ////////////////////////////////////////
  task automatic t_sel;
    cw(3'h3); chk(src_o, pisc_src_fm);
    cw(3'h6); chk({src_o, am_band_short_o}, {pisc_src_am_sw, 1'b1});
    cw(3'h7); chk({src_o, am_band_short_o}, {pisc_src_am_mw, 1'b0});
    cw(3'h4); chk({src_o, div_in_o}, {pisc_src_none, 1'b0});
    cw(3'h7); chk({src_o, am_band_short_o}, {pisc_src_am_mw, 1'b0});
    $display("sel done");
  endtask
  task automatic t_pump;
    pc(1'b1, 1'b0); chk(pv, 4'hB);
    pc(1'b0, 1'b1); chk(pv, 4'hE);
    pc(1'b1, 1'b1); chk({pv[3], pv[1]}, 4'h0);
    $display("pump done");
  endtask
  task automatic t_gate;
    for (int i = 0; i < 4; i++) begin
      pc(1'b1, 1'b0);
      @(posedge clk_i);
      {hold_en_i, clock_stop_i, por_i, synth_stop_i} <= 4'(4'h8 >> i);
      hold_n_i <= 1'b0;
      wt;
      chk({div_in_o, pv[3], pv[1]}, 4'h0);
      @(posedge clk_i);
      {hold_en_i, clock_stop_i, por_i, synth_stop_i, hold_n_i} <= 5'h01;
    end
    $display("gate done");
  endtask
  task automatic t_sub;
    sl(`PISC_SUB_UP); chk({sub_pump_output_oe_o, sub_pump_output_o}, 4'h3);
    sl(`PISC_SUB_DN); chk({sub_pump_output_oe_o, sub_pump_output_o}, 4'h2);
    sl(`PISC_SUB_AUTO); chk(sub_pump_output_oe_o, 4'h1);
    sl(`PISC_SUB_OFF); chk(sub_pump_output_oe_o, 4'h0);
    $display("sub done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_sel;
    t_pump;
    t_gate;
    t_sub;
    close_out;
  end
  // tests need about 80 cycles; allow twenty-five times that
  initial begin
    #100000;
    fail_count++;
    close_out;
  end
endmodule
`default_nettype wire
